// ### hdl/ccm_regs.vh
// Register offsets, field positions and reset values of the capture/compare module
`ifndef CCM_REGS_VH
`define CCM_REGS_VH

// Register byte addresses on the special-function register bus
`define CCM_MODE_ADDR        8'hda
`define CCM_CMP_LOW_ADDR     8'hfb
`define CCM_CMP_HIGH_ADDR    8'hfc
`define CCM_FLAG_ADDR        8'hf9

// Field positions in the module mode register
`define CCM_WIDE_PULSE_BIT   7
`define CCM_CMP_EN_BIT       6
`define CCM_RISE_CAP_BIT     5
`define CCM_FALL_CAP_BIT     4
`define CCM_EQ_EVENT_BIT     3
`define CCM_FLIP_BIT         2
`define CCM_PULSE_BIT        1
`define CCM_FLAG_IRQ_BIT     0

// Field position in the flag register
`define CCM_EQ_FLAG_BIT      0

// Reset values
`define CCM_MODE_RESET       8'h00
`define CCM_CMP_RESET        16'h0000

// Narrowest PWM resolution in bits, and the mask of the widest one
`define CCM_PWM_MIN_BITS     8
`define CCM_PWM_MAX_MASK     16'h07ff
`define CCM_COUNT_TOP        16'hffff

`endif

// ### hdl/ccm_capture_compare.v
// One capture/compare module of a programmable counter array
// How it works
// - N-bit PWM output high while counter low N bits are at or above compare.
// - Wide PWM compares the full 16-bit counter against the full compare word.
// - Wide PWM runs only with compare, pulse width and wide select all set.
// - Wide PWM with equality events sets the flag on match and PWM level up edges.
// - Counter wrap, the PWM down edge, pulses the overflow flag set output.
// - Low byte write clears compare enable; high byte write sets it.
// - Mode bit 7 picks 8 to 11-bit or 16-bit PWM, only while PWM is on.
// - Mode bit 6 enables comparing the counter against the compare value.
// - Mode bit 5 captures the counter on a rising module input edge.
// - Mode bit 4 captures the counter on a falling module input edge.
// - Mode bit 3 sets the equality flag whenever counter equals compare.
// - Mode bit 2 inverts the output pin on each counter equality.
// - Toggle plus pulse width enables make a frequency output generator.
// - Mode bit 1 drives a pulse width modulated waveform on the output pin.
// - Mode bit 0 enables the flag interrupt request; clear, it masks it.
`timescale 1ns/1ps
`include "ccm_regs.vh"
`default_nettype none

module ccm_capture_compare (
	input  wire        clk,
	input  wire        resetn,
	input  wire [7:0]  sfr_addr,
	input  wire        sfr_wr,
	input  wire [7:0]  sfr_wdata,
	input  wire        sfr_rd,
	output reg  [7:0]  sfr_rdata,
	input  wire        count_tick,
	input  wire [15:0] counter_value,
	input  wire [1:0]  pwm_resolution,
	input  wire        output_polarity_invert,
	input  wire        capture_in,
	output reg         module_output_pin,
	output reg         flag_irq,
	output reg         counter_overflow_event
);

	reg  [7:0]  module_mode_control_0;
	reg  [15:0] compare_word;
	reg         module_equal_flag;
	reg         flip_level;
	reg         capture_prev;
	reg         pwm_prev;

	// Next-state values of the registers below
	reg  [7:0]  next_mode;
	reg  [15:0] next_compare;
	reg         next_flag;
	reg         next_flip;
	reg         next_pin;
	reg  [7:0]  next_rdata;
	reg         next_irq;
	reg         next_ovf;
	// Frequency-mode step; the carry is dropped so the low byte wraps
	wire [8:0]  freq_step = {1'b0, compare_word[7:0]} + {1'b0, compare_word[15:8]};

	// Limitations worth knowing:
	//   compare is not double-buffered, so a mid-period write can cut one period
	//   a capture overwrites the compare word, so capture and compare modes clash
	//   count_tick gates equality, the PWM up-edge flag event and the overflow pulse; the PWM level follows counter_value always
	//   the overflow pulse feeds the shared counter flag, no copy is kept here
	//   the pin is registered, one clock behind the PWM level and two behind a toggle equality
	//   polarity inversion touches the PWM waveform, not toggle or frequency output
	//   software writes the compare low byte first, which also disarms the compare

	// Decoded mode fields
	wire wide_pulse_select;
	wire compare_enable;
	wire rising_capture_enable;
	wire falling_capture_enable;
	wire equality_event_enable;
	wire flip_on_equal_enable;
	wire pulse_width_enable;
	wire flag_interrupt_enable;
	// Field taps of the mode register
	assign wide_pulse_select      = module_mode_control_0[`CCM_WIDE_PULSE_BIT];
	assign compare_enable         = module_mode_control_0[`CCM_CMP_EN_BIT];
	assign rising_capture_enable  = module_mode_control_0[`CCM_RISE_CAP_BIT];
	assign falling_capture_enable = module_mode_control_0[`CCM_FALL_CAP_BIT];
	assign equality_event_enable  = module_mode_control_0[`CCM_EQ_EVENT_BIT];
	assign flip_on_equal_enable   = module_mode_control_0[`CCM_FLIP_BIT];
	assign pulse_width_enable     = module_mode_control_0[`CCM_PULSE_BIT];
	assign flag_interrupt_enable  = module_mode_control_0[`CCM_FLAG_IRQ_BIT];

	// Bus write strobes
	wire wr_mode;
	wire wr_low;
	wire wr_high;
	wire wr_flag;
	// Address decode, one register per strobe
	assign wr_mode = sfr_wr && (sfr_addr == `CCM_MODE_ADDR);
	assign wr_low  = sfr_wr && (sfr_addr == `CCM_CMP_LOW_ADDR);
	assign wr_high = sfr_wr && (sfr_addr == `CCM_CMP_HIGH_ADDR);
	assign wr_flag = sfr_wr && (sfr_addr == `CCM_FLAG_ADDR);

	// Mode byte decoding, most specific first:
	//   toggle and pwm      -> frequency output, low byte advances by high byte
	//   cmp, pwm and wide   -> 16-bit PWM on the full counter
	//   pwm, wide clear     -> 8 to 11-bit PWM on the low N counter bits
	//   toggle alone        -> pin flips on each full 16-bit equality
	//   none of the above   -> pin low, or output_polarity_invert if pwm is set
	// Capture edges work beside any of these output modes
	// Wide select without compare enable leaves the PWM level low

	// Operating modes; frequency output takes priority over plain PWM
	wire freq_mode = pulse_width_enable && flip_on_equal_enable;
	wire wide_mode = compare_enable && pulse_width_enable && wide_pulse_select
		&& !flip_on_equal_enable;
	wire narrow_mode = pulse_width_enable && !wide_pulse_select && !flip_on_equal_enable;
	wire flip_mode = flip_on_equal_enable && !pulse_width_enable;

	// Resolution mask for N = 8..11; shifting down avoids a wide variable shift
	wire [15:0] res_mask = `CCM_PWM_MAX_MASK >> (2'd3 - pwm_resolution);
	wire [15:0] cnt_n    = counter_value & res_mask;
	wire [15:0] cmp_n    = compare_word & res_mask;

	// Equality only counts on a counter tick with compare enabled
	wire eq_full  = count_tick && compare_enable
		&& (counter_value == compare_word);
	wire eq_low   = count_tick && compare_enable
		&& (counter_value[7:0] == compare_word[7:0]);
	wire eq_n     = count_tick && compare_enable && (cnt_n == cmp_n);

	// PWM level before polarity; with compare disabled the match never comes
	wire pwm_narrow = compare_enable && (cnt_n >= cmp_n);
	wire pwm_wide   = compare_enable && (counter_value >= compare_word);
	wire pwm_level  = wide_mode ? pwm_wide : pwm_narrow;
	wire pwm_up     = pwm_level && !pwm_prev;

	// Capture edges of the module input, sampled synchronously
	wire cap_rise = rising_capture_enable && capture_in && !capture_prev;
	wire cap_fall = falling_capture_enable && !capture_in && capture_prev;
	wire cap_hit  = cap_rise || cap_fall;

	// Events that set the equality flag
	wire match_set = equality_event_enable && (
		wide_mode   ? (eq_full || (count_tick && pwm_up)) :
		narrow_mode ? eq_n :
		freq_mode   ? eq_low :
		eq_full);
	wire flag_set  = match_set || cap_hit;

	// Next mode byte; the compare byte writes steer the compare enable bit
	always @* begin
		next_mode = module_mode_control_0;
		if (wr_mode) begin
			next_mode = sfr_wdata;
		end else if (wr_low) begin
			next_mode[`CCM_CMP_EN_BIT] = 1'b0;
		end else if (wr_high) begin
			next_mode[`CCM_CMP_EN_BIT] = 1'b1;
		end
	end

	// Mode register
	always @(posedge clk) begin
		if (!resetn) begin
			module_mode_control_0 <= `CCM_MODE_RESET;
		end else begin
			module_mode_control_0 <= next_mode;
		end
	end

	// Next compare word: software bytes, capture and frequency-mode advance
	// A capture in the same cycle as a byte write wins, so no edge is lost
	always @* begin
		next_compare = compare_word;
		if (cap_hit) begin
			next_compare = counter_value;
		end else if (wr_low) begin
			next_compare[7:0] = sfr_wdata;
		end else if (wr_high) begin
			next_compare[15:8] = sfr_wdata;
		end else if (freq_mode && eq_low) begin
			// Next toggle point is one half period further on
			next_compare[7:0] = freq_step[7:0];
		end
	end

	// Compare word register
	always @(posedge clk) begin
		if (!resetn) begin
			compare_word <= `CCM_CMP_RESET;
		end else begin
			compare_word <= next_compare;
		end
	end

	// Next equality flag; a set in the clearing cycle wins
	always @* begin
		next_flag = module_equal_flag;
		if (flag_set) begin
			next_flag = 1'b1;
		end else if (wr_flag) begin
			next_flag = sfr_wdata[`CCM_EQ_FLAG_BIT];
		end
	end

	// Sticky equality flag register
	always @(posedge clk) begin
		if (!resetn) begin
			module_equal_flag <= 1'b0;
		end else begin
			module_equal_flag <= next_flag;
		end
	end

	// Next toggle and frequency output level
	always @* begin
		next_flip = flip_level;
		if ((flip_mode && eq_full) || (freq_mode && eq_low)) begin
			next_flip = !flip_level;
		end
	end

	// Toggle level register
	always @(posedge clk) begin
		if (!resetn) begin
			flip_level <= 1'b0;
		end else begin
			flip_level <= next_flip;
		end
	end

	// Edge history for capture and PWM up-edge detection
	always @(posedge clk) begin
		if (!resetn) begin
			capture_prev <= 1'b0;
			pwm_prev     <= 1'b0;
		end else begin
			capture_prev <= capture_in;
			pwm_prev     <= pwm_level;
		end
	end

	// Next pin level; polarity applies to the PWM waveform only
	always @* begin
		if (pulse_width_enable && !flip_on_equal_enable) begin
			next_pin = pwm_level ^ output_polarity_invert;
		end else if (flip_on_equal_enable) begin
			next_pin = flip_level;
		end else begin
			next_pin = 1'b0;
		end
	end

	// Output pin register
	always @(posedge clk) begin
		if (!resetn) begin
			module_output_pin <= 1'b0;
		end else begin
			module_output_pin <= next_pin;
		end
	end

	// Interrupt request follows the flag only while unmasked
	always @* begin
		next_irq = flag_interrupt_enable && module_equal_flag;
		next_ovf = count_tick && (counter_value == `CCM_COUNT_TOP);
	end

	// Interrupt request and counter wrap pulse, registered
	always @(posedge clk) begin
		if (!resetn) begin
			flag_irq               <= 1'b0;
			counter_overflow_event <= 1'b0;
		end else begin
			flag_irq               <= next_irq;
			counter_overflow_event <= next_ovf;
		end
	end

	// Next read data; unmapped reads give zero, no read holds the last value
	always @* begin
		next_rdata = sfr_rdata;
		if (sfr_rd) begin
			case (sfr_addr)
				`CCM_MODE_ADDR:     next_rdata = module_mode_control_0;
				`CCM_CMP_LOW_ADDR:  next_rdata = compare_word[7:0];
				`CCM_CMP_HIGH_ADDR: next_rdata = compare_word[15:8];
				`CCM_FLAG_ADDR:     next_rdata = {7'h00, module_equal_flag};
				default:            next_rdata = 8'h00;
			endcase
		end
	end

	// Read data register, valid one cycle after the read strobe
	always @(posedge clk) begin
		if (!resetn) begin
			sfr_rdata <= 8'h00;
		end else begin
			sfr_rdata <= next_rdata;
		end
	end

endmodule // ccm_capture_compare

`default_nettype wire

// ### test/ccm_pin_load.sv
// Far-side load on the module output pin, tallying its high cycles
`timescale 1ns/1ps
`default_nettype none
module ccm_pin_load (
	input  wire logic        clk,
	input  wire logic        pin,
	input  wire logic        tally_clr,
	output var  logic [15:0] high_cycles
);
	// Sampled on the launch edge, so one count per clock spent high
	always @(posedge clk) begin
		if (tally_clr) begin
			high_cycles <= 16'h0000;
		end else if (pin) begin
			high_cycles <= high_cycles + 16'h0001;
		end
	end
endmodule // ccm_pin_load
`default_nettype wire

// ### test/ccm_checker_assertions.sv
// Port assertions for the capture/compare module
`timescale 1ns/1ps
`default_nettype none
module ccm_checker (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic [7:0]  sfr_wdata,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_rdata,
	input wire logic        count_tick,
	input wire logic [15:0] counter_value,
	input wire logic [1:0]  pwm_resolution,
	input wire logic        output_polarity_invert,
	input wire logic        module_output_pin,
	input wire logic        flag_irq,
	input wire logic        counter_overflow_event
);
	logic [7:0]  mode_s;
	logic [15:0] cmp_s;
	logic [15:0] mask;
	logic        lvl;
	// Shadow of mode and compare from bus writes; stale after a capture
	always_ff @(posedge clk) begin
		if (!resetn) begin
			mode_s <= 8'h00;
			cmp_s <= 16'h0000;
		end else if (sfr_wr && sfr_addr == 8'hda) begin
			mode_s <= sfr_wdata;
		end else if (sfr_wr && sfr_addr == 8'hfb) begin
			cmp_s[7:0] <= sfr_wdata;
			mode_s[6] <= 1'b0;
		end else if (sfr_wr && sfr_addr == 8'hfc) begin
			cmp_s[15:8] <= sfr_wdata;
			mode_s[6] <= 1'b1;
		end
	end
	// Expected PWM level
	assign mask = mode_s[7] ? 16'hffff : ((16'h0100 << pwm_resolution) - 16'h0001);
	assign lvl = ((counter_value & mask) >= (cmp_s & mask)) ^ output_polarity_invert;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_match;
		count_tick && mode_s[6] && counter_value == cmp_s && !mode_s[1];
	endsequence
	sequence s_narrow;
		(mode_s[6] && mode_s[1] && !mode_s[7] && !mode_s[2])[*2];
	endsequence
	sequence s_wide;
		(mode_s[6] && mode_s[1] && mode_s[7] && !mode_s[2])[*2];
	endsequence
	a_ovf_after_wrap: assert property (count_tick && counter_value == 16'hffff |=>
		counter_overflow_event) else $error("overflow pulse missing");
	a_ovf_has_cause: assert property (counter_overflow_event |->
		$past(count_tick && counter_value == 16'hffff)) else $error("stray overflow");
	a_irq_masked: assert property (!mode_s[0] |=> !flag_irq) else $error("irq unmasked");
	a_mode_readback: assert property (sfr_rd && sfr_addr == 8'hda |=>
		sfr_rdata == $past(mode_s)) else $error("mode readback");
	a_unmapped_zero: assert property (sfr_rd && sfr_addr == 8'h80 |=>
		sfr_rdata == 8'h00) else $error("unmapped read");
	a_toggle_flip: assert property (s_match ##0 mode_s[2] |-> ##2
		module_output_pin != $past(module_output_pin)) else $error("no toggle");
	a_flag_irq_set: assert property (s_match ##0 (mode_s[3] && mode_s[0]) |-> ##2
		flag_irq) else $error("no irq");
	a_narrow_pwm: assert property (s_narrow |-> module_output_pin == $past(lvl))
		else $error("narrow pwm level");
	a_wide_pwm: assert property (s_wide |-> module_output_pin == $past(lvl))
		else $error("wide pwm level");
endmodule // ccm_checker
bind ccm_capture_compare ccm_checker i_ccm_checker (.*);
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the capture/compare module
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
	logic        count_tick = 1'b0, output_polarity_invert = 1'b0, capture_in = 1'b0;
	logic        tally_clr = 1'b1, module_output_pin, flag_irq, counter_overflow_event;
	logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rv;
	logic [15:0] counter_value = 16'h0000, high_cycles;
	logic [1:0]  pwm_resolution = 2'b00;
	int          bad_count = 0, samples_checked = 0;
	ccm_capture_compare i_ccm_capture_compare (.*);
	ccm_pin_load i_ccm_pin_load (.clk(clk), .pin(module_output_pin), .tally_clr(tally_clr),
		.high_cycles(high_cycles));
	initial forever #10 clk = ~clk;
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Bus strobes are one cycle wide, launched at the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		rv = sfr_rdata;
	endtask
	// Single tick, then time for flag, pin and request to settle
	task automatic tick(input logic [15:0] v);
		@(negedge clk);
		counter_value = v;
		count_tick = 1'b1;
		@(negedge clk);
		count_tick = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic set_cmp(input logic [15:0] v);
		wr(8'hfb, v[7:0]);
		wr(8'hfc, v[15:8]);
	endtask
	task automatic t_regs();
		rd(8'hda);
		chk("mode reset", 16'h0000, {8'h00, rv});
		wr(8'hda, 8'hff);
		wr(8'hfb, 8'h12);
		rd(8'hda);
		chk("mode low", 16'h00bf, {8'h00, rv});
		wr(8'hfc, 8'h34);
		rd(8'hda);
		chk("mode high", 16'h00ff, {8'h00, rv});
		wr(8'h80, 8'h55);
		rd(8'h80);
		chk("unmapped", 16'h0000, {8'h00, rv});
		$display("regs done");
	endtask
	task automatic t_toggle();
		logic p0;
		wr(8'hda, 8'h00);
		wr(8'hf9, 8'h00);
		set_cmp(16'h0005);
		wr(8'hda, 8'h4d);
		p0 = module_output_pin;
		tick(16'h0005);
		chk("toggle", {15'h0, ~p0}, {15'h0, module_output_pin});
		chk("irq", 16'h0001, {15'h0, flag_irq});
		rd(8'hf9);
		chk("flag", 16'h0001, {15'h0, rv[0]});
		wr(8'hf9, 8'h00);
		wr(8'hda, 8'h4c);
		tick(16'h0005);
		chk("toggle back", {15'h0, p0}, {15'h0, module_output_pin});
		chk("irq masked", 16'h0000, {15'h0, flag_irq});
		$display("toggle done");
	endtask
	// Two windows of 2^N ticks: first settles, second is tallied
	task automatic t_pwm(input logic [1:0] res, input logic pol, input logic [15:0] exp);
		pwm_resolution = res;
		output_polarity_invert = pol;
		set_cmp(16'h0040);
		wr(8'hda, 8'h42);
		for (int i = 0; i < (512 << res); i++) begin
			@(negedge clk);
			count_tick = 1'b1;
			counter_value = counter_value + 16'h0001;
			tally_clr = (i < (256 << res));
		end
		@(negedge clk);
		count_tick = 1'b0;
		chk("pwm high", exp, high_cycles);
		tally_clr = 1'b1;
		$display("pwm done");
	endtask
	task automatic t_wide();
		output_polarity_invert = 1'b0;
		wr(8'hf9, 8'h00);
		set_cmp(16'h0100);
		wr(8'hda, 8'hca);
		tick(16'h00ff);
		chk("wide below", 16'h0000, {15'h0, module_output_pin});
		tick(16'h0100);
		chk("wide at", 16'h0001, {15'h0, module_output_pin});
		rd(8'hf9);
		chk("wide flag", 16'h0001, {15'h0, rv[0]});
		wr(8'hf9, 8'h00);
		tick(16'h00ff);
		tick(16'h0180);
		rd(8'hf9);
		chk("wide up edge", 16'h0001, {15'h0, rv[0]});
		tick(16'hffff);
		wr(8'hfb, 8'h00);
		tick(16'h0200);
		chk("wide disarmed", 16'h0000, {15'h0, module_output_pin});
		$display("wide done");
	endtask
	task automatic t_capture();
		wr(8'hda, 8'h20);
		wr(8'hf9, 8'h00);
		counter_value = 16'h1234;
		capture_in = 1'b1;
		repeat (4) @(negedge clk);
		rd(8'hfb);
		chk("rise cap", 16'h0034, {8'h00, rv});
		rd(8'hf9);
		chk("cap flag", 16'h0001, {15'h0, rv[0]});
		wr(8'hda, 8'h10);
		counter_value = 16'h5678;
		capture_in = 1'b0;
		repeat (4) @(negedge clk);
		rd(8'hfc);
		chk("fall cap", 16'h0056, {8'h00, rv});
		$display("capture done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		t_regs();
		t_toggle();
		t_pwm(2'd0, 1'b0, 16'd192);
		t_pwm(2'd1, 1'b1, 16'd64);
		t_pwm(2'd3, 1'b0, 16'd1984);
		t_wide();
		t_capture();
		complete_run();
	end
	// Run needs about 5800 cycles
	initial begin
		#600000;
		bad_count++;
		complete_run();
	end
endmodule // tb
`default_nettype wire
